//--- bench/pid_mode_supervisor_test.sv
// Purpose: self-checking bench for pms_supervisor
// Assumes: short suspension tick so delays stay a few cycles
// Notes:   random values from a fixed xorshift seed
`timescale 1ns/1ps
module pid_mode_supervisor_test;
    import pms_pkg::*;
    localparam int TICK = 4;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, start_i, jog_i, ack_o, pid_select_input_i;
    logic [3:0]  sel_i, spd;
    logic [7:0]  adr_i;
    logic [31:0] dat_i, dat_o, seed, q;
    logic [15:0] output_freq_i, pid_freq_i, sp_t, pv_t, setpoint_i, measured_i, p, pv;
    logic [15:0] freq_cmd_o, panel_display_o, analog_monitor_output_o, main_accel_time_o;
    logic        pid_active_o, running_o, suspended_o, pid_seed_zero_o, remote_enable_o;
    logic        override_o, sleep_terminal_o;
    logic [7:0]  code;
    int          miscompares, n_compared, n;

    pms_supervisor #(.TICK_LEN(TICK)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .start_i(start_i), .output_freq_i(output_freq_i), .pid_freq_i(pid_freq_i),
        .setpoint_i(setpoint_i), .measured_i(measured_i),
        .pid_select_input_i(pid_select_input_i), .speed_select_high_i(spd[0]),
        .speed_select_mid_i(spd[1]), .speed_select_low_i(spd[2]),
        .speed_select_extended_i(spd[3]), .jog_i(jog_i), .pid_active_o(pid_active_o),
        .running_o(running_o), .suspended_o(suspended_o), .pid_seed_zero_o(pid_seed_zero_o),
        .remote_enable_o(remote_enable_o), .override_o(override_o), .freq_cmd_o(freq_cmd_o),
        .sleep_terminal_o(sleep_terminal_o), .panel_display_o(panel_display_o),
        .analog_monitor_output_o(analog_monitor_output_o),
        .main_accel_time_o(main_accel_time_o)
    );
    pms_process_model pm_u (.clk_i(clk_i), .sp_target_i(sp_t), .pv_target_i(pv_t),
        .setpoint_o(setpoint_i), .measured_o(measured_i));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [15:0] clampf(input logic [15:0] v, lo, hi);
        return (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : clampf
    function automatic logic sig(input int k);
        return (k == 0) ? pid_active_o : suspended_o;
    endfunction : sig
    task automatic results();
        if (miscompares == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // returns on an edge; outputs read there hold the values of the cycle before it
    task automatic wt(input int c);
        repeat (c) @(posedge clk_i);
    endtask : wt
    task automatic wait_for(input int k, input logic v);
        n = 0;
        while (sig(k) !== v && n < 60)
        begin
            wt(1);
            n++;
        end
        chk(sig(k), v);
    endtask : wait_for
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do
        begin
            @(posedge clk_i);
            t++;
        end while (ack_o !== 1'b1 && t < 50);
        q = dat_o;
        chk(ack_o, 32'h1);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        wt(1);
    endtask : wb

    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    initial
    begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        results();
    end
    initial
    begin
        {rst_i, cyc_i, stb_i, we_i, start_i, jog_i, pid_select_input_i} = 7'h40;
        {spd, sel_i, adr_i, dat_i} = {4'h0, 4'hF, 8'h00, 32'h0000_0000};
        {output_freq_i, pid_freq_i, sp_t, pv_t} = 64'h0;
        {miscompares, n_compared, seed} = {32'h0, 32'h0, 32'h0000_7A77};
        wt(2);
        rst_i <= 1'b0;
        wt(1);
        chk(remote_enable_o, 32'h1);
        wb(0, ADDR_GAIN_FREQ, 0); chk(q, 32'h0000_1388);
        wb(0, ADDR_CANCEL_LVL, 0); chk(q, 32'h0000_2710);
        wb(0, ADDR_LIMITS, 0); chk(q, 32'h2EE0_0000);
        wb(0, ADDR_PROC_CAL, 0); chk(q, 32'h03E8_0000);
        wb(1, 8'hFC, 32'hFFFF_FFFF); wb(0, 8'hFC, 0); chk(q, 32'h0);
        wb(1, ADDR_ACCEL, 32'h0064); chk(main_accel_time_o, 32'h0064);
        wb(1, ADDR_ACCEL, 32'h1388); chk(main_accel_time_o, ACCEL_MAX);
        // normal start-up, then switchover at 10 Hz
        wb(1, ADDR_CTRL, 32'h4014);
        wb(1, ADDR_SWITCH_FREQ, 32'h03E8);
        output_freq_i <= 16'h01F4;
        start_i <= 1'b1;
        wt(4);
        chk({pid_active_o, running_o}, 32'h1);
        output_freq_i <= 16'h03E8;
        wait_for(0, 1'b1);
        chk(pid_seed_zero_o, 32'h1);
        chk(remote_enable_o, 32'h0);
        output_freq_i <= 16'h00C8;
        wt(6);
        chk(pid_active_o, 32'h1);
        // pid clamp: calibration bounds first, general limits after
        wb(1, ADDR_BIAS_FREQ, 32'h03E8);
        wb(1, ADDR_GAIN_FREQ, 32'h0BB8);
        wb(1, ADDR_LIMITS, 32'h09C4_05DC);
        for (int i = 0; i < 10; i++)
        begin
            p = (i == 0) ? 16'h0000 : ((i == 1) ? 16'hFFFF : rnd() % 4000);
            pid_freq_i <= p;
            wt(2);
            chk(freq_cmd_o, clampf(clampf(p, 16'h03E8, 16'h0BB8), 16'h05DC, 16'h09C4));
        end
        // suspension after two ticks below 5 Hz
        wb(1, ADDR_CTRL, 32'hC014);
        // delay first, or a zero delay suspends at once
        wb(1, ADDR_SUSP_DELAY, 32'h0002);
        wb(1, ADDR_SUSP_FREQ, 32'h01F4);
        sp_t <= 16'h012C;
        pv_t <= 16'h01F4;
        pid_freq_i <= 16'h0064;
        wait_for(1, 1'b1);
        chk(n >= 5 && n <= 30, 32'h1);
        chk({running_o, pid_active_o, freq_cmd_o}, 32'h1_0000);
        wb(1, ADDR_SELECT, 32'h0046); chk(sleep_terminal_o, 32'h1);
        wb(1, ADDR_SELECT, 32'h00AA); chk(sleep_terminal_o, 32'h0);
        wb(1, ADDR_CANCEL_LVL, 32'h2742);
        sp_t <= 16'h021C;
        wt(4);
        chk(suspended_o, 32'h1);
        sp_t <= 16'h0230;
        wait_for(1, 1'b0);
        pid_freq_i <= 16'h07D0;
        chk(pid_active_o, 32'h1);
        // monitor selectors with random values
        for (int i = 0; i < 12; i++)
        begin
            code = 8'h34 + i % 3;
            p = rnd() % 1500;
            pv = rnd() % 1200;
            sp_t <= p;
            pv_t <= pv;
            wb(1, ADDR_SELECT, {8'h00, code, code, 8'h00});
            wt(2);
            pv = clampf(pv, 16'h0000, FULL_SCALE);
            chk(panel_display_o, (code == MON_SETPOINT) ? p : ((code == MON_MEASURED) ? pv
                : p - pv + DEV_OFFSET));
            chk(analog_monitor_output_o, (code == MON_DEVIATION) ? 16'h0000
                : clampf((code == MON_SETPOINT) ? p : pv, 16'h0000, FULL_SCALE));
        end
        // each way of taking pid away
        for (int k = 0; k < 9; k++)
        begin
            wb(1, ADDR_CTRL, 32'h0014);
            wait_for(0, 1'b1);
            chk(pid_active_o, 32'h1);
            case (k)
                0: jog_i <= 1'b1;
                1, 2, 3, 4: spd <= 4'h1 << (k - 1);
                5: wb(1, ADDR_CTRL, 32'h0614);
                6: wb(1, ADDR_CTRL, 32'h0000);
                7: wb(1, ADDR_CTRL, 32'h2014);
                default: wb(1, ADDR_CTRL, 32'h1014);
            endcase
            if (k == 8)
                start_i <= 1'b0;
            wt(4);
            chk(pid_active_o, 32'h0);
            if (k < 5)
                chk(override_o, 32'h1);
            jog_i <= 1'b0;
            spd <= 4'h0;
            start_i <= 1'b1;
        end
        results();
    end
endmodule : pid_mode_supervisor_test

//--- bench/pms_monitor.sv
// Purpose: port-level checks for pms_supervisor
// Assumes: one clock, synchronous active-high reset
// Notes:   bound into every supervisor instance
`timescale 1ns/1ps
module pms_monitor
    import pms_pkg::*;
(
    // clock, reset and bus
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        ack_o,
    // drive side
    input  wire logic        start_i,
    input  wire logic        jog_i,
    input  wire logic        pid_active_o,
    input  wire logic        running_o,
    input  wire logic        suspended_o,
    input  wire logic        pid_seed_zero_o,
    input  wire logic        remote_enable_o,
    input  wire logic [15:0] freq_cmd_o,
    input  wire logic [15:0] analog_monitor_output_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("bus request not acknowledged next cycle");
    AST_ACK_ONE: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    AST_SUSP_STATUS: assert property (suspended_o |-> pid_active_o && !running_o)
        else $error("status outputs wrong while suspended");
    AST_SUSP_STOP: assert property (suspended_o |-> freq_cmd_o == 16'h0000)
        else $error("output not stopped while suspended");
    AST_REMOTE_OFF: assert property (pid_active_o |-> !remote_enable_o)
        else $error("remote speed setting live during pid");
    AST_SEED: assert property (pid_seed_zero_o |-> pid_active_o && !$past(pid_active_o))
        else $error("seed pulse outside switchover");
    AST_JOG: assert property (jog_i [*3] |-> !pid_active_o)
        else $error("pid kept running under jog");
    AST_RUN: assert property (!$past(start_i) |-> !running_o)
        else $error("running without a start command");
    AST_AM_SCALE: assert property (analog_monitor_output_o <= FULL_SCALE)
        else $error("analog monitor beyond full scale");

    cover property (suspended_o);
    cover property (pid_seed_zero_o);
    cover property ($fell(suspended_o) && pid_active_o);
endmodule : pms_monitor

bind pms_supervisor pms_monitor mon_u (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
    .start_i(start_i), .jog_i(jog_i), .pid_active_o(pid_active_o),
    .running_o(running_o), .suspended_o(suspended_o), .pid_seed_zero_o(pid_seed_zero_o),
    .remote_enable_o(remote_enable_o), .freq_cmd_o(freq_cmd_o),
    .analog_monitor_output_o(analog_monitor_output_o)
);

//--- bench/pms_process_model.sv
// Purpose: detector and set-point source facing the supervisor
// Assumes: bench chooses the physical targets
// Notes:   one cycle of conversion delay, like a sampled converter
`timescale 1ns/1ps
module pms_process_model
    import pms_pkg::*;
(
    // clock
    input  wire logic        clk_i,
    // targets
    input  wire logic [15:0] sp_target_i,
    input  wire logic [15:0] pv_target_i,
    // drive side
    output logic      [15:0] setpoint_o,
    output logic      [15:0] measured_o
);
    always_ff @(posedge clk_i)
    begin
        setpoint_o <= sp_target_i;
        // detector saturates at its 100 % point
        measured_o <= (pv_target_i > FULL_SCALE) ? FULL_SCALE : pv_target_i;
    end
endmodule : pms_process_model

//--- rtl/pms_pkg.sv
// Purpose: constants for the pid mode supervisor
// Assumes: frequencies in 0.01 Hz units, percentages in 0.1 % units
// Notes:   register map sits on a classic wishbone slave
package pms_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_SWITCH_FREQ = 8'h04;
    localparam logic [7:0] ADDR_SUSP_FREQ = 8'h08;
    localparam logic [7:0] ADDR_SUSP_DELAY = 8'h0C;
    localparam logic [7:0] ADDR_CANCEL_LVL = 8'h10;
    localparam logic [7:0] ADDR_SELECT    = 8'h14;
    localparam logic [7:0] ADDR_BIAS_FREQ = 8'h18;
    localparam logic [7:0] ADDR_GAIN_FREQ = 8'h1C;
    localparam logic [7:0] ADDR_LIMITS    = 8'h20;
    localparam logic [7:0] ADDR_PROC_CAL  = 8'h24;
    localparam logic [7:0] ADDR_STATUS    = 8'h28;
    localparam logic [7:0] ADDR_FREQ_CMD  = 8'h2C;
    localparam logic [7:0] ADDR_MONITOR   = 8'h30;
    localparam logic [7:0] ADDR_ACCEL     = 8'h34;

    // control field positions
    localparam int CTRL_ACTION_LSB  = 0;   // pid_action_selection, 8 bits
    localparam int CTRL_OPMODE_LSB  = 8;   // operation_mode_selection, 4 bits
    localparam int CTRL_PFSTOP_BIT  = 12;  // power_failure_stop_selection
    localparam int CTRL_X14ASG_BIT  = 13;  // a terminal carries pid_select_input
    localparam int CTRL_SWEN_BIT    = 14;  // switchover frequency in use
    localparam int CTRL_SUSPEN_BIT  = 15;  // suspension in use

    // codes
    localparam logic [7:0] ACTION_OFF     = 8'h00;
    localparam logic [3:0] OPMODE_SWITCH  = 4'h6;
    localparam logic [7:0] OUT_SLEEP_POS  = 8'h46;  // 70
    localparam logic [7:0] OUT_SLEEP_NEG  = 8'hAA;  // 170
    localparam logic [7:0] MON_SETPOINT   = 8'h34;  // 52
    localparam logic [7:0] MON_MEASURED   = 8'h35;  // 53
    localparam logic [7:0] MON_DEVIATION  = 8'h36;  // 54
    localparam logic [15:0] DEV_OFFSET    = 16'h2710; // 1000.0 % in 0.1 %
    localparam logic [15:0] FULL_SCALE    = 16'h03E8; // 100.0 % in 0.1 %
    localparam logic [15:0] SWITCH_MAX    = 16'h9C40; // 400.00 Hz
    localparam logic [15:0] ACCEL_MAX     = 16'h0E10; // 3600

    // reset values
    localparam logic [15:0] RST_ZERO      = 16'h0000;
    localparam logic [15:0] RST_GAIN_FREQ = 16'h1388; // 50.00 Hz
    localparam logic [15:0] RST_MAX_FREQ  = 16'h2EE0; // 120.00 Hz

    // suspension delay tick: 0.1 s at 200 MHz
    localparam int CLK_HZ      = 200_000_000;
    localparam int TICK_MS     = 100;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

    typedef enum logic [1:0] {
        PMS_IDLE    = 2'b00,
        PMS_NORMAL  = 2'b01,
        PMS_PID     = 2'b10,
        PMS_SUSPEND = 2'b11
    } pms_state_t;
endpackage : pms_pkg

//--- rtl/pms_supervisor.sv
// Purpose: supervisory control around a process pid loop
// Assumes: pid arithmetic outside; all inputs synchronous to clk_i
// Notes:   frequencies 0.01 Hz, percentages 0.1 %
// Functional notes
// - normal mode until switchover frequency reached
// - stay in pid after falling below threshold
// - suspend after low frequency beyond delay
// - resume when deviation reaches cancel level
// - suspended: sleep on, run off, pid on
// - terminal code 70 positive, 170 inverted sleep
// - codes 52,53,54 select setpoint, measured, deviation
// - deviation monitor offset: 1000 means zero
// - analog monitor full scale 100%, no deviation
// - multi-speed or jog overrides pid
// - operation mode 6 disables pid
// - power-failure stop while stopped disables pid
// - pid frequency clamped by bias/gain and limits
// - remote speed setting off during pid
// - switchover seeds pid from 0 Hz
// - setpoint calibration bias/gain frequencies bound the pid frequency
// - process calibration holds bias/gain percentages
// - second accel time is main-speed accel
// - action 0 or select off means normal
// - unassigned select terminal: action setting alone
`timescale 1ns/1ps
module pms_supervisor
    import pms_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES
)(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // drive inputs
    input  wire logic        start_i,
    input  wire logic [15:0] output_freq_i,
    input  wire logic [15:0] pid_freq_i,
    input  wire logic [15:0] setpoint_i,
    input  wire logic [15:0] measured_i,
    input  wire logic        pid_select_input_i,
    input  wire logic        speed_select_high_i,
    input  wire logic        speed_select_mid_i,
    input  wire logic        speed_select_low_i,
    input  wire logic        speed_select_extended_i,
    input  wire logic        jog_i,
    // status and commands
    output logic             pid_active_o,
    output logic             running_o,
    output logic             suspended_o,
    output logic             pid_seed_zero_o,
    output logic             remote_enable_o,
    output logic             override_o,
    output logic [15:0]      freq_cmd_o,
    output logic             sleep_terminal_o,
    output logic [15:0]      panel_display_o,
    output logic [15:0]      analog_monitor_output_o,
    output logic [15:0]      main_accel_time_o
);

    logic [15:0] ctrl;
    logic [15:0] switchover_frequency;
    logic [15:0] suspension_frequency;
    logic [15:0] suspension_delay_time;
    logic [15:0] suspension_cancel_level;
    logic [23:0] selectors;
    logic [15:0] setpoint_bias_calibration;
    logic [15:0] setpoint_gain_frequency;
    logic [31:0] limits;
    logic [31:0] process_cal;
    logic [15:0] second_accel_time;
    pms_state_t  state;
    pms_state_t  next_state;
    logic [31:0] tick_cnt;
    logic [15:0] delay_cnt;
    logic        ack;
    logic [31:0] rdata;

    function automatic logic [15:0] wmask(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        wmask = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : wmask

    function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
        clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : clamp

    // pid enable decode
    logic        action_on;
    logic        select_on;
    logic        pid_invalid;
    logic        overriding;
    logic        pid_allowed;
    logic signed [17:0] deviation;
    logic signed [17:0] cancel_level;
    logic        low_freq;
    assign action_on   = ctrl[CTRL_ACTION_LSB +: 8] != ACTION_OFF;
    // unassigned select terminal leaves the action setting in charge
    assign select_on   = ctrl[CTRL_X14ASG_BIT] ? pid_select_input_i : 1'b1;
    assign pid_invalid = (ctrl[CTRL_OPMODE_LSB +: 4] == OPMODE_SWITCH)
                       || (ctrl[CTRL_PFSTOP_BIT] && !start_i);
    assign overriding  = speed_select_high_i || speed_select_mid_i || speed_select_low_i
                       || speed_select_extended_i || jog_i;
    assign pid_allowed = action_on && select_on && !pid_invalid && !overriding;
    assign deviation   = $signed({2'b00, setpoint_i}) - $signed({2'b00, measured_i});
    assign cancel_level = $signed({2'b00, suspension_cancel_level})
                        - $signed({2'b00, DEV_OFFSET});
    assign low_freq    = pid_freq_i < suspension_frequency;

    // state machine, evaluated each cycle
    always_comb
    begin
        next_state = state;
        case (state)
            PMS_IDLE:
            begin
                if (start_i && pid_allowed)
                begin
                    if (ctrl[CTRL_SWEN_BIT] && output_freq_i < switchover_frequency)
                        next_state = PMS_NORMAL;
                    else
                        next_state = PMS_PID;
                end
            end
            PMS_NORMAL:
            begin
                if (!start_i || !pid_allowed)
                    next_state = PMS_IDLE;
                else if (output_freq_i >= switchover_frequency)
                    next_state = PMS_PID;
            end
            PMS_PID:
            begin
                // falling below the switchover point does not leave pid
                if (!start_i || !pid_allowed)
                    next_state = PMS_IDLE;
                else if (ctrl[CTRL_SUSPEN_BIT] && low_freq
                         && delay_cnt >= suspension_delay_time)
                    next_state = PMS_SUSPEND;
            end
            PMS_SUSPEND:
            begin
                if (!start_i || !pid_allowed)
                    next_state = PMS_IDLE;
                else if (deviation >= cancel_level)
                    next_state = PMS_PID;
            end
            default: next_state = PMS_IDLE;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            state <= PMS_IDLE;
        else
            state <= next_state;
    end

    // suspension delay counted in 0.1 s ticks while low
    always_ff @(posedge clk_i)
    begin
        if (rst_i || state != PMS_PID || !low_freq)
        begin
            tick_cnt  <= '0;
            delay_cnt <= RST_ZERO;
        end
        else if (tick_cnt == 32'(TICK_LEN - 1))
        begin
            tick_cnt <= '0;
            if (delay_cnt != 16'hFFFF)
                delay_cnt <= delay_cnt + 16'h0001;
        end
        else
            tick_cnt <= tick_cnt + 32'h0000_0001;
    end

    // status outputs follow the registered state
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pid_active_o     <= 1'b0;
            running_o        <= 1'b0;
            suspended_o      <= 1'b0;
            pid_seed_zero_o  <= 1'b0;
            remote_enable_o  <= 1'b1;
            override_o       <= 1'b0;
            sleep_terminal_o <= 1'b0;
            freq_cmd_o       <= RST_ZERO;
        end
        else
        begin
            pid_active_o    <= next_state == PMS_PID || next_state == PMS_SUSPEND;
            running_o       <= start_i && next_state != PMS_SUSPEND;
            suspended_o     <= next_state == PMS_SUSPEND;
            // pid integrator restarts from 0 Hz, not from the running frequency
            pid_seed_zero_o <= next_state == PMS_PID && state == PMS_NORMAL;
            remote_enable_o <= !(next_state == PMS_PID || next_state == PMS_SUSPEND);
            override_o      <= action_on && select_on && overriding;
            case (selectors[7:0])
                OUT_SLEEP_POS: sleep_terminal_o <= next_state == PMS_SUSPEND;
                OUT_SLEEP_NEG: sleep_terminal_o <= next_state != PMS_SUSPEND;
                default:       sleep_terminal_o <= 1'b0;
            endcase
            if (next_state == PMS_SUSPEND)
                freq_cmd_o <= RST_ZERO;
            else if (next_state == PMS_PID)
                freq_cmd_o <= clamp(clamp(pid_freq_i, setpoint_bias_calibration,
                                          setpoint_gain_frequency),
                                    limits[15:0], limits[31:16]);
            else
                freq_cmd_o <= clamp(output_freq_i, limits[15:0], limits[31:16]);
        end
    end

    // monitors
    logic [15:0] dev_shown;
    assign dev_shown = 16'(deviation + $signed({2'b00, DEV_OFFSET}));
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            panel_display_o         <= RST_ZERO;
            analog_monitor_output_o <= RST_ZERO;
        end
        else
        begin
            case (selectors[15:8])
                MON_SETPOINT:  panel_display_o <= setpoint_i;
                MON_MEASURED:  panel_display_o <= measured_i;
                MON_DEVIATION: panel_display_o <= dev_shown;
                default:       panel_display_o <= RST_ZERO;
            endcase
            // deviation is not a source here; values cap at full scale
            case (selectors[23:16])
                MON_SETPOINT:  analog_monitor_output_o <= clamp(setpoint_i, RST_ZERO,
                                                                FULL_SCALE);
                MON_MEASURED:  analog_monitor_output_o <= clamp(measured_i, RST_ZERO,
                                                                FULL_SCALE);
                default:       analog_monitor_output_o <= RST_ZERO;
            endcase
        end
    end

    // second accel time drives main speed accel in dancer control
    assign main_accel_time_o = second_accel_time;

    // register writes
    logic wr;
    assign wr = cyc_i && stb_i && we_i && !ack;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl                      <= RST_ZERO;
            switchover_frequency      <= RST_ZERO;
            suspension_frequency      <= RST_ZERO;
            suspension_delay_time     <= RST_ZERO;
            suspension_cancel_level   <= DEV_OFFSET;
            selectors                 <= '0;
            setpoint_bias_calibration <= RST_ZERO;
            setpoint_gain_frequency   <= RST_GAIN_FREQ;
            limits                    <= {RST_MAX_FREQ, RST_ZERO};
            process_cal               <= {FULL_SCALE, RST_ZERO};
            second_accel_time         <= RST_ZERO;
        end
        else if (wr)
        begin
            case (adr_i)
                ADDR_CTRL:        ctrl <= wmask(ctrl, dat_i, sel_i);
                ADDR_SWITCH_FREQ: switchover_frequency <= clamp(
                                      wmask(switchover_frequency, dat_i, sel_i),
                                      RST_ZERO, SWITCH_MAX);
                ADDR_SUSP_FREQ:   suspension_frequency <= wmask(suspension_frequency,
                                                                dat_i, sel_i);
                ADDR_SUSP_DELAY:  suspension_delay_time <= wmask(suspension_delay_time,
                                                                 dat_i, sel_i);
                ADDR_CANCEL_LVL:  suspension_cancel_level <= wmask(suspension_cancel_level,
                                                                   dat_i, sel_i);
                ADDR_SELECT:
                begin
                    if (sel_i[0]) selectors[7:0]   <= dat_i[7:0];
                    if (sel_i[1]) selectors[15:8]  <= dat_i[15:8];
                    if (sel_i[2]) selectors[23:16] <= dat_i[23:16];
                end
                ADDR_BIAS_FREQ:   setpoint_bias_calibration <= wmask(
                                      setpoint_bias_calibration, dat_i, sel_i);
                ADDR_GAIN_FREQ:   setpoint_gain_frequency <= wmask(
                                      setpoint_gain_frequency, dat_i, sel_i);
                ADDR_LIMITS:
                begin
                    limits[15:0]  <= wmask(limits[15:0], dat_i, sel_i);
                    limits[31:16] <= wmask(limits[31:16], dat_i >> 16, sel_i >> 2);
                end
                ADDR_PROC_CAL:
                begin
                    process_cal[15:0]  <= wmask(process_cal[15:0], dat_i, sel_i);
                    process_cal[31:16] <= wmask(process_cal[31:16], dat_i >> 16,
                                                sel_i >> 2);
                end
                ADDR_ACCEL:       second_accel_time <= clamp(
                                      wmask(second_accel_time, dat_i, sel_i),
                                      RST_ZERO, ACCEL_MAX);
                default: ;
            endcase
        end
    end

    // read mux; unmapped addresses read zero and are still acked
    always_comb
    begin
        case (adr_i)
            ADDR_CTRL:        rdata = {16'h0000, ctrl};
            ADDR_SWITCH_FREQ: rdata = {16'h0000, switchover_frequency};
            ADDR_SUSP_FREQ:   rdata = {16'h0000, suspension_frequency};
            ADDR_SUSP_DELAY:  rdata = {16'h0000, suspension_delay_time};
            ADDR_CANCEL_LVL:  rdata = {16'h0000, suspension_cancel_level};
            ADDR_SELECT:      rdata = {8'h00, selectors};
            ADDR_BIAS_FREQ:   rdata = {16'h0000, setpoint_bias_calibration};
            ADDR_GAIN_FREQ:   rdata = {16'h0000, setpoint_gain_frequency};
            ADDR_LIMITS:      rdata = limits;
            ADDR_PROC_CAL:    rdata = process_cal;
            ADDR_STATUS:      rdata = {26'h0, override_o, remote_enable_o, suspended_o,
                                       running_o, pid_active_o, state == PMS_NORMAL};
            ADDR_FREQ_CMD:    rdata = {16'h0000, freq_cmd_o};
            ADDR_MONITOR:     rdata = {analog_monitor_output_o, panel_display_o};
            ADDR_ACCEL:       rdata = {16'h0000, second_accel_time};
            default:          rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack   <= 1'b0;
            dat_o <= 32'h0000_0000;
        end
        else
        begin
            ack   <= cyc_i && stb_i && !ack;
            dat_o <= rdata;
        end
    end
    assign ack_o = ack;

endmodule : pms_supervisor
